// >>> src/fbsm_mapper.sv
// FSK bit-to-symbol mapper top
`default_nettype none
`include "fbsm_consts.svh"
module fbsm_mapper
    import fbsm_pkg::*;
#(
    parameter int CW = 12
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    input  wire logic [1:0]        i_rate,
    input  wire logic              i_uplink,
    input  wire logic              i_eu_band,
    input  wire logic              i_psdu_position_mod_select,
    input  wire logic              i_coding_enable_attr,
    input  wire logic              i_whiten_enable,
    input  wire logic              i_spread_enable,
    input  wire logic [6:0]        i_preamble_octet_count,
    input  wire logic              i_pn9_start,
    input  wire logic              i_bit_valid,
    output logic                   o_bit_ready,
    input  wire logic [1:0]        i_bit_data,
    input  wire logic [2:0]        i_bit_field,
    input  wire logic              i_bit_last,
    output logic                   o_dev_positive,
    output logic                   o_dev_active,
    output logic                   o_sym_strobe,
    output logic                   o_gauss_en,
    output logic [3:0]             o_mod_index_x2,
    output logic [CW-1:0]          o_sym_period_cyc,
    output logic [CW-1:0]          o_timing_sym_cyc,
    output logic                   o_code_block,
    output logic                   o_whiten_bit,
    output logic                   o_spread_bit,
    output logic                   o_busy,
    output logic                   o_cfg_error
);
    // Word is {last, field[2:0], bit1, bit0}
    fbsm_buf_if #(.W(6)) bus ();
    fbsm_state_t   st_q;
    fbsm_rate_t    rate_q;
    logic [CW-1:0] period_q;
    logic          pos_q;
    logic          pair_late_q;
    logic          last_q;
    logic          mid_q;
    logic [9:0]    pre_cnt_q;
    logic          pre_bad_q;
    logic [8:0]    pn_q;
    logic [9:0]    pn_cnt_q;
    logic          tick;
    logic          run;
    logic          take;
    logic          use_pos;
    logic [2:0]    fld;

    function automatic logic [CW-1:0] sym_cyc(input fbsm_rate_t r);
        unique case (r)
            FBSM_RATE_HI:  sym_cyc = CW'(`FBSM_SYM_CYC(`FBSM_RATE_HI_BPS));
            FBSM_RATE_MID: sym_cyc = CW'(`FBSM_SYM_CYC(`FBSM_RATE_MID_BPS));
            FBSM_RATE_LO:  sym_cyc = CW'(`FBSM_SYM_CYC(`FBSM_RATE_LO_BPS));
            default:       sym_cyc = CW'(`FBSM_SYM_CYC(`FBSM_RATE_MID_BPS));
        endcase
    endfunction : sym_cyc

    function automatic logic [3:0] mod_idx(input fbsm_rate_t r);
        unique case (r)
            FBSM_RATE_HI:  mod_idx = `FBSM_MODIDX_HI_X2;
            FBSM_RATE_MID: mod_idx = `FBSM_MODIDX_MID_X2;
            FBSM_RATE_LO:  mod_idx = `FBSM_MODIDX_LO_X2;
            default:       mod_idx = `FBSM_MODIDX_MID_X2;
        endcase
    endfunction : mod_idx

    fbsm_skid #(.W(6), .DEPTH(2)) u_buf (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_valid (i_bit_valid),
        .o_ready (o_bit_ready),
        .i_data  ({i_bit_last, i_bit_field, i_bit_data}),
        .out     (bus)
    );

    assign run = (st_q != FBSM_IDLE);

    fbsm_tick #(.CW(CW)) u_tick (
        .i_clk    (i_clk),
        .i_rst_b  (i_rst_b),
        .i_run    (run),
        .i_period (period_q),
        .o_tick   (tick)
    );

    assign fld     = bus.data[4:2];
    // Position mode only for PSDU, never at 12.5 kbps
    assign use_pos = i_psdu_position_mod_select && (fld == FBSM_FIELD_PSDU)
                     && (rate_q != FBSM_RATE_LO);
    // Word accepted when idle, or when a binary symbol or a whole pair ends
    assign take = bus.valid && ((st_q == FBSM_IDLE) ||
                  (tick && !last_q &&
                   ((st_q == FBSM_SYM && !pos_q) || st_q == FBSM_SLOT)));
    assign bus.ready = take;

    // Rate latched only while idle so a frame keeps one rate
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rate_q   <= FBSM_RATE_MID;
            period_q <= CW'(`FBSM_SYM_CYC(`FBSM_RATE_MID_BPS));
        end
        else if (st_q == FBSM_IDLE)
        begin
            rate_q   <= fbsm_rate_t'(i_rate);
            period_q <= sym_cyc(fbsm_rate_t'(i_rate));
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_mod_index_x2   <= `FBSM_MODIDX_MID_X2;
            o_sym_period_cyc <= CW'(`FBSM_SYM_CYC(`FBSM_RATE_MID_BPS));
            o_timing_sym_cyc <= CW'(`FBSM_SYM_CYC_STD);
            o_gauss_en       <= 1'b0;
            o_cfg_error      <= 1'b0;
        end
        else
        begin
            // Modulator derives deviation as rate * index / 2
            o_mod_index_x2   <= mod_idx(rate_q);
            o_sym_period_cyc <= period_q;
            o_timing_sym_cyc <= i_eu_band ? CW'(`FBSM_SYM_CYC_EU)
                                          : CW'(`FBSM_SYM_CYC_STD);
            o_gauss_en       <= i_uplink;
            o_cfg_error      <= (i_uplink && rate_q == FBSM_RATE_LO)
                                || (rate_q == fbsm_rate_t'(2'h3))
                                || pre_bad_q;
        end
    end

    // Symbol sequencer
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st_q        <= FBSM_IDLE;
            pos_q       <= 1'b0;
            pair_late_q <= 1'b0;
            last_q      <= 1'b0;
        end
        else if (take)
        begin
            last_q      <= bus.data[5];
            pos_q       <= use_pos;
            pair_late_q <= use_pos & bus.data[1];
            st_q        <= FBSM_SYM;
        end
        else
        begin
            unique case (st_q)
                FBSM_IDLE:
                begin
                    if (i_pn9_start)
                    begin
                        st_q   <= FBSM_PN;
                        pos_q  <= 1'b0;
                        last_q <= 1'b0;
                    end
                end
                FBSM_SYM:
                begin
                    if (tick)
                    begin
                        if (pos_q)
                        begin
                            st_q <= FBSM_SLOT;
                        end
                        else if (last_q || !bus.valid)
                        begin
                            st_q <= FBSM_IDLE;
                        end
                    end
                end
                FBSM_SLOT:
                begin
                    if (tick)
                    begin
                        st_q <= FBSM_IDLE;
                    end
                end
                FBSM_PN:
                begin
                    if (tick && pn_cnt_q == `FBSM_PN9_LEN)
                    begin
                        st_q <= FBSM_IDLE;
                    end
                end
                default:
                begin
                    st_q <= FBSM_IDLE;
                end
            endcase
        end
    end

    // PN9 generator, x^9 + x^5 + 1
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pn_q     <= `FBSM_PN9_SEED;
            pn_cnt_q <= 10'h000;
        end
        else if (st_q != FBSM_PN)
        begin
            pn_q     <= `FBSM_PN9_SEED;
            pn_cnt_q <= 10'h001;
        end
        else if (tick)
        begin
            pn_q     <= {pn_q[7:0], pn_q[8] ^ pn_q[4]};
            pn_cnt_q <= pn_cnt_q + 10'h001;
        end
    end

    // High between the first and the last word of a frame
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            mid_q <= 1'b0;
        end
        else if (take)
        begin
            mid_q <= !bus.data[5];
        end
    end

    // Preamble words counted and held against the configured octet count
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pre_cnt_q <= 10'h000;
            pre_bad_q <= 1'b0;
        end
        else if (take)
        begin
            if (fld == FBSM_FIELD_PRE)
            begin
                pre_cnt_q <= (mid_q ? pre_cnt_q : 10'h000) + 10'h001;
                if (!mid_q)
                begin
                    pre_bad_q <= 1'b0;
                end
            end
            else
            begin
                pre_cnt_q <= 10'h000;
                // Only a frame that carries a preamble is judged
                if (!mid_q)
                begin
                    pre_bad_q <= 1'b0;
                end
                else if (pre_cnt_q != 10'h000)
                begin
                    pre_bad_q <= (pre_cnt_q != {i_preamble_octet_count, 3'h0});
                end
            end
        end
    end

    // Modulator outputs, registered
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_dev_positive <= 1'b0;
            o_dev_active   <= 1'b0;
            o_sym_strobe   <= 1'b0;
            o_code_block   <= 1'b0;
            o_whiten_bit   <= 1'b0;
            o_spread_bit   <= 1'b0;
            o_busy         <= 1'b0;
        end
        else
        begin
            // Busy from the cycle of the first strobe on
            o_busy       <= run || take || (st_q == FBSM_IDLE && i_pn9_start);
            o_sym_strobe <= take || (tick && run) ||
                            (st_q == FBSM_IDLE && i_pn9_start);
            if (take)
            begin
                o_dev_positive <= bus.data[0];
                // Late pair: first slot idle
                o_dev_active   <= !(use_pos && bus.data[1]);
                o_code_block   <= i_coding_enable_attr &&
                                  (fld == FBSM_FIELD_PHR || fld == FBSM_FIELD_PSDU);
                o_whiten_bit   <= i_whiten_enable && (fld == FBSM_FIELD_PSDU);
                o_spread_bit   <= i_spread_enable &&
                                  (fld == FBSM_FIELD_PHR || fld == FBSM_FIELD_PSDU);
            end
            else if (tick && st_q == FBSM_SYM && pos_q)
            begin
                o_dev_active <= pair_late_q;
            end
            else if (st_q == FBSM_PN || (st_q == FBSM_IDLE && i_pn9_start))
            begin
                o_dev_positive <= pn_q[8];
                o_dev_active   <= 1'b1;
                o_whiten_bit   <= 1'b0;
                o_spread_bit   <= 1'b0;
                o_code_block   <= 1'b0;
            end
            else if (tick && (st_q == FBSM_SYM || st_q == FBSM_SLOT))
            begin
                o_dev_active <= 1'b0;
            end
        end
    end
endmodule : fbsm_mapper
`default_nettype wire

// >>> src/fbsm_consts.svh
// Constants for the FSK bit-to-symbol mapper
`ifndef FBSM_CONSTS_SVH
`define FBSM_CONSTS_SVH
`define FBSM_CLK_HZ            40000000
`define FBSM_RATE_HI_BPS       37500
`define FBSM_RATE_MID_BPS      25000
`define FBSM_RATE_LO_BPS       12500
`define FBSM_SYM_CYC(bps)      ((`FBSM_CLK_HZ) / (bps))
`define FBSM_SYM_US_X100_STD   2667
`define FBSM_SYM_US_X100_EU    4000
`define FBSM_SYM_CYC_STD       (((`FBSM_SYM_US_X100_STD) * 40) / 100)
`define FBSM_SYM_CYC_EU        (((`FBSM_SYM_US_X100_EU) * 40) / 100)
`define FBSM_PREAMBLE_OCTET    8'h55
`define FBSM_MODIDX_HI_X2      4'h1
`define FBSM_MODIDX_MID_X2     4'h2
`define FBSM_MODIDX_LO_X2      4'h8
`define FBSM_PN9_SEED          9'h1ff
`define FBSM_PN9_LEN           10'h1ff
`endif

// >>> src/fbsm_pkg.sv
// Types for the FSK bit-to-symbol mapper
`default_nettype none
package fbsm_pkg;
    typedef enum logic [1:0] {
        FBSM_RATE_HI  = 2'h0,
        FBSM_RATE_MID = 2'h1,
        FBSM_RATE_LO  = 2'h2
    } fbsm_rate_t;
    typedef enum logic [2:0] {
        FBSM_FIELD_PRE = 3'h0,
        FBSM_FIELD_SFD = 3'h1,
        FBSM_FIELD_PHR = 3'h2,
        FBSM_FIELD_PSDU = 3'h3
    } fbsm_field_t;
    typedef enum logic [2:0] {
        FBSM_IDLE = 3'b000,
        FBSM_SYM  = 3'b001,
        FBSM_SLOT = 3'b011,
        FBSM_PN   = 3'b010
    } fbsm_state_t;
endpackage : fbsm_pkg
`default_nettype wire

// >>> src/fbsm_buf_if.sv
// Valid/ready word channel between buffer and mapper
`default_nettype none
interface fbsm_buf_if #(parameter int W = 4);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : fbsm_buf_if
`default_nettype wire

// >>> src/fbsm_skid.sv
// Two-entry buffer on the bit path
`default_nettype none
module fbsm_skid #(
    parameter int W     = 4,
    parameter int DEPTH = 2
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_b,
    input  wire logic         i_valid,
    output logic              o_ready,
    input  wire logic [W-1:0] i_data,
    fbsm_buf_if.src           out
);
    logic [W-1:0] mem_q [DEPTH];
    logic         wp_q;
    logic         rp_q;
    logic [1:0]   cnt_q;
    logic         push;
    logic         pop;

    assign o_ready   = (cnt_q != 2'h2);
    assign push      = i_valid && o_ready;
    assign pop       = out.valid && out.ready;
    assign out.valid = (cnt_q != 2'h0);
    assign out.data  = mem_q[rp_q];

    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem_q[wp_q] <= i_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                wp_q <= ~wp_q;
            end
            if (pop)
            begin
                rp_q <= ~rp_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : fbsm_skid
`default_nettype wire

// >>> src/fbsm_tick.sv
// Symbol-rate enable divider
`default_nettype none
module fbsm_tick #(
    parameter int CW = 12
) (
    input  wire logic          i_clk,
    input  wire logic          i_rst_b,
    input  wire logic          i_run,
    input  wire logic [CW-1:0] i_period,
    output logic               o_tick
);
    logic [CW-1:0] cnt_q;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cnt_q  <= '0;
            o_tick <= 1'b0;
        end
        else if (!i_run)
        begin
            cnt_q  <= '0;
            o_tick <= 1'b0;
        end
        else if (cnt_q >= i_period - CW'(1))
        begin
            cnt_q  <= '0;
            o_tick <= 1'b1;
        end
        else
        begin
            cnt_q  <= cnt_q + CW'(1);
            o_tick <= 1'b0;
        end
    end
endmodule : fbsm_tick
`default_nettype wire

// >>> dv/fbsm_mapper_monitor.sv
// Port-level checks for the FSK bit-to-symbol mapper
`default_nettype none
module fbsm_mapper_monitor #(
    parameter int CW = 12
) (
    input wire logic          i_clk,
    input wire logic          i_rst_b,
    input wire logic          i_uplink,
    input wire logic          i_eu_band,
    input wire logic          i_whiten_enable,
    input wire logic          o_sym_strobe,
    input wire logic          o_busy,
    input wire logic          o_gauss_en,
    input wire logic [3:0]    o_mod_index_x2,
    input wire logic [CW-1:0] o_sym_period_cyc,
    input wire logic [CW-1:0] o_timing_sym_cyc,
    input wire logic          o_whiten_bit
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] since_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    // Cycles since the last symbol boundary, saturating
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            since_q <= 16'h0;
        else if (!o_busy)
            since_q <= 16'h0;
        else if (o_sym_strobe)
            since_q <= 16'h1;
        else if (since_q != 16'h0 && since_q != 16'hffff)
            since_q <= since_q + 16'h1;
    end

    sequence s_one_pulse;
        o_sym_strobe ##1 !o_sym_strobe;
    endsequence

    sequence s_index_of_rate;
        (o_sym_period_cyc == 12'h42a && o_mod_index_x2 == 4'h1)
        || (o_sym_period_cyc == 12'h640 && o_mod_index_x2 == 4'h2)
        || (o_sym_period_cyc == 12'hc80 && o_mod_index_x2 == 4'h8);
    endsequence

    strobe_one_cycle_a: assert property (o_sym_strobe |-> s_one_pulse)
        else $error("symbol strobe wider than one cycle");
    symbol_spacing_a: assert property (
        o_sym_strobe && since_q != 16'h0 |-> since_q >= 16'(o_sym_period_cyc))
        else $error("symbol boundaries closer than one period");
    strobe_in_frame_a: assert property (o_sym_strobe |-> o_busy)
        else $error("symbol strobe outside a frame");
    index_rate_a: assert property (o_busy |-> s_index_of_rate)
        else $error("modulation index does not match symbol period");
    timing_symbol_a: assert property (
        o_busy |-> o_timing_sym_cyc == (i_eu_band ? 12'h640 : 12'h42a))
        else $error("timing symbol length wrong for band");
    gauss_follow_a: assert property (o_busy |-> o_gauss_en == $past(i_uplink))
        else $error("filter select does not follow direction");
    rate_fixed_a: assert property (
        o_busy && $past(o_busy) |-> $stable(o_sym_period_cyc))
        else $error("symbol period changed inside a frame");
    whiten_scope_a: assert property (o_busy && o_whiten_bit |-> i_whiten_enable)
        else $error("whitening flagged while disabled");
endmodule : fbsm_mapper_monitor

bind fbsm_mapper fbsm_mapper_monitor #(.CW(CW)) u_monitor (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_uplink(i_uplink), .i_eu_band(i_eu_band),
    .i_whiten_enable(i_whiten_enable), .o_sym_strobe(o_sym_strobe), .o_busy(o_busy),
    .o_gauss_en(o_gauss_en), .o_mod_index_x2(o_mod_index_x2),
    .o_sym_period_cyc(o_sym_period_cyc), .o_timing_sym_cyc(o_timing_sym_cyc),
    .o_whiten_bit(o_whiten_bit)
);
`default_nettype wire

// >>> dv/fbsm_mac_src.sv
// Behavioural MAC-side bit source feeding the mapper
`default_nettype none
module fbsm_mac_src (
    input  wire logic       i_clk,
    input  wire logic       i_ready,
    input  wire logic [7:0] i_gap,
    output logic            o_valid,
    output logic [1:0]      o_data,
    output logic [2:0]      o_field,
    output logic            o_last
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0] q[$];
    logic       took = 1'b0;

    // Acceptance as seen at the edge, before the buffer count moves
    always @(posedge i_clk) took <= o_valid & i_ready;

    initial
    begin
        {o_valid, o_last, o_field, o_data} = 7'h0;
        forever
        begin
            @(posedge i_clk);
            #1;
            if (q.size() != 0)
            begin
                {o_last, o_field, o_data} = q.pop_front();
                o_valid = 1'b1;
                do
                begin
                    @(posedge i_clk);
                    #1;
                end
                while (!took);
                // Released lines show the inverse of the last word
                o_valid = 1'b0;
                {o_last, o_field, o_data} = ~{o_last, o_field, o_data};
                repeat (i_gap) @(posedge i_clk);
            end
        end
    end
endmodule : fbsm_mac_src
`default_nettype wire

// >>> dv/tb_fsk_bit_to_symbol_mapper.sv
// Self-checking bench for the FSK bit-to-symbol mapper
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_fsk_bit_to_symbol_mapper
    import fbsm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst_b, up, eu, psel, cen, wen, sen, valid, last, ready, full;
    logic        pos, act, stb, busy, gau, cbk, wbt, sbt, cerr, pn;
    logic [1:0]  rate, data;
    logic [2:0]  fld;
    logic [3:0]  idx;
    logic [11:0] per, tim;
    logic [7:0]  gap;
    logic [5:0]  wq[$];
    int          n_fail, comparisons;

    fbsm_mapper DUT (
        .i_clk(clk), .i_rst_b(rst_b), .i_rate(rate), .i_uplink(up), .i_eu_band(eu),
        .i_psdu_position_mod_select(psel), .i_coding_enable_attr(cen),
        .i_whiten_enable(wen), .i_spread_enable(sen), .i_preamble_octet_count(7'h01),
        .i_pn9_start(pn), .i_bit_valid(valid), .o_bit_ready(ready), .i_bit_data(data),
        .i_bit_field(fld), .i_bit_last(last), .o_dev_positive(pos), .o_dev_active(act),
        .o_sym_strobe(stb), .o_gauss_en(gau), .o_mod_index_x2(idx), .o_sym_period_cyc(per),
        .o_timing_sym_cyc(tim), .o_code_block(cbk), .o_whiten_bit(wbt),
        .o_spread_bit(sbt), .o_busy(busy), .o_cfg_error(cerr)
    );
    fbsm_mac_src mac (
        .i_clk(clk), .i_ready(ready), .i_gap(gap), .o_valid(valid), .o_data(data),
        .o_field(fld), .o_last(last)
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) if (!rst_b) full <= 1'b0; else if (!ready) full <= 1'b1;
    initial
    begin
        repeat (80000) @(posedge clk);
        n_fail++;
        stop_test();
    end

    task automatic stop_test();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc

    task automatic setup(input logic [1:0] r, input logic [5:0] c, input logic [7:0] g);
        {up, eu, psel, cen, wen, sen} = c;
        rate = r;
        gap = g;
    endtask : setup

    task automatic add(input logic [2:0] f, input logic [1:0] d);
        wq.push_back({1'b0, f, d});
    endtask : add

    // Sends the queued frame and judges every symbol at mid-period
    task automatic play(input logic [11:0] p, input logic [3:0] i, input logic ce);
        logic [5:0] w;
        logic       ps;
        logic       ph;
        int         n;
        wq[wq.size() - 1][5] = 1'b1;
        foreach (wq[k]) mac.q.push_back(wq[k]);
        foreach (wq[k])
        begin
            w = wq[k];
            ps = psel && w[4:2] == FBSM_FIELD_PSDU && rate != 2'h2;
            ph = w[4:2] >= FBSM_FIELD_PHR;
            n = 0;
            do
            begin
                cyc(1);
                n++;
            end
            while (!stb && n < 5000);
            `CHK("strobe", 1'b1, stb)
            `CHK("period", p, per)
            `CHK("index", i, idx)
            `CHK("cfg error", ce, cerr)
            cyc(p / 2);
            `CHK("active", ps ? ~w[1] : 1'b1, act)
            if (act === 1'b1) `CHK("sign", w[0], pos)
            `CHK("whiten", wen && w[4:2] == FBSM_FIELD_PSDU, wbt)
            `CHK("spread", sen && ph, sbt)
            `CHK("coding", cen && ph, cbk)
            if (ps)
            begin
                cyc(p);
                `CHK("late slot", w[1], act)
                if (act === 1'b1) `CHK("late sign", w[0], pos)
            end
        end
        n = 0;
        while (busy !== 1'b0 && n < 8000)
        begin
            cyc(1);
            n++;
        end
        `CHK("idle", 1'b0, busy)
        wq.delete();
    endtask : play

    task automatic t_reset();
        `CHK("reset index", 4'h2, idx)
        `CHK("reset period", 12'h640, per)
        `CHK("reset timing", 12'h42a, tim)
        `CHK("reset busy", 1'b0, busy)
        $display("Test reset done");
    endtask : t_reset

    task automatic t_full_frame();
        setup(2'h0, 6'b101111, 8'h0);
        for (int b = 0; b < 8; b++) add(FBSM_FIELD_PRE, {1'b0, b[0]});
        add(FBSM_FIELD_SFD, 2'h1);
        add(FBSM_FIELD_SFD, 2'h0);
        add(FBSM_FIELD_PHR, 2'h3);
        add(FBSM_FIELD_PHR, 2'h0);
        for (int d = 0; d < 4; d++) add(FBSM_FIELD_PSDU, {d[0], d[1]});
        play(12'h42a, 4'h1, 1'b0);
        `CHK("buffer refused", 1'b1, full)
        `CHK("buffer drained", 1'b1, ready)
        `CHK("gaussian", 1'b1, gau)
        `CHK("timing", 12'h42a, tim)
        $display("Test full frame done");
    endtask : t_full_frame

    task automatic t_slow_binary();
        setup(2'h1, 6'b010000, 8'h1e);
        add(FBSM_FIELD_PHR, 2'h1);
        add(FBSM_FIELD_PSDU, 2'h2);
        add(FBSM_FIELD_PSDU, 2'h3);
        play(12'h640, 4'h2, 1'b0);
        `CHK("plain fsk", 1'b0, gau)
        `CHK("timing", 12'h640, tim)
        $display("Test slow binary done");
    endtask : t_slow_binary

    task automatic t_low_rate();
        setup(2'h2, 6'b001010, 8'h0);
        add(FBSM_FIELD_PSDU, 2'h3);
        add(FBSM_FIELD_PSDU, 2'h2);
        play(12'hc80, 4'h8, 1'b0);
        $display("Test low rate done");
    endtask : t_low_rate

    task automatic t_cfg_error();
        setup(2'h3, 6'b000001, 8'h0);
        add(FBSM_FIELD_PSDU, 2'h1);
        play(12'h640, 4'h2, 1'b1);
        setup(2'h2, 6'b100000, 8'h0);
        add(FBSM_FIELD_PSDU, 2'h0);
        play(12'hc80, 4'h8, 1'b1);
        setup(2'h1, 6'b000000, 8'h0);
        add(FBSM_FIELD_PRE, 2'h0);
        add(FBSM_FIELD_PRE, 2'h1);
        add(FBSM_FIELD_PSDU, 2'h1);
        play(12'h640, 4'h2, 1'b0);
        `CHK("short preamble", 1'b1, cerr)
        $display("Test config error done");
    endtask : t_cfg_error

    task automatic t_pn9();
        logic [10:0] exp_bits;
        int          n;
        exp_bits = 11'h7fc;
        setup(2'h0, 6'b000111, 8'h0);
        cyc(2);
        pn = 1'b1;
        cyc(1);
        pn = 1'b0;
        for (int j = 10; j >= 0; j--)
        begin
            n = 0;
            while (stb !== 1'b1 && n < 3000)
            begin
                cyc(1);
                n++;
            end
            `CHK("pn strobe", 1'b1, stb)
            cyc(12'h42a / 2);
            `CHK("pn bit", exp_bits[j], pos)
            `CHK("pn active", 1'b1, act)
            `CHK("pn whiten", 1'b0, wbt)
        end
        // Reset in mid-burst: outputs back to rest at once
        rst_b = 1'b0;
        cyc(2);
        `CHK("abort busy", 1'b0, busy)
        `CHK("abort active", 1'b0, act)
        `CHK("abort error", 1'b0, cerr)
        rst_b = 1'b1;
        cyc(4);
        `CHK("rest strobe", 1'b0, stb)
        `CHK("rest busy", 1'b0, busy)
        $display("Test pn9 done");
    endtask : t_pn9

    initial
    begin
        {rst_b, rate, gap, pn} = 12'h0;
        {up, eu, psel, cen, wen, sen} = 6'h0;
        n_fail = 0;
        comparisons = 0;
        repeat (5) @(posedge clk);
        #1;
        t_reset();
        rst_b = 1'b1;
        t_full_frame();
        t_slow_binary();
        t_low_rate();
        t_cfg_error();
        t_pn9();
        stop_test();
    end
endmodule : tb_fsk_bit_to_symbol_mapper
`default_nettype wire
